/* synth_serial_program_regs.sv */
// Three-wire serial programming front end with latch bank and field decode
`timescale 1ns/1ns
// Contract
// - Words are 24 bits sent MSB first, one bit shifted per serial clock rising edge.
// - The low two bits are the latch select code and the upper 22 bits are payload.
// - A load strobe rising edge copies the shift register into exactly one of four latches.
// - Codes 00,01,10,11 select IF reference, IF feedback, RF reference, RF feedback.
// - Counter settings are 15 bits except the RF feedback setting of 19 bits.
// - IF reference word holds sharing, modulus, mux select, pump word and divide ratio.
// - With sharing set the IF reference input clocks both reference counters.
// - Modulus select 1 gives fractional modulus 16, else 15.
// - Reference divide ratios run 3 to 32767 and the device divides by the programmed value.
// - Pump gain 0 gives 1X current and 1 gives 8X current.
// - Detector polarity 1 is positive and 0 negative.
// - The mux select routes lock detects or counter outputs to the multifunction pin.
// - RF reference word holds calibration speed, doubler enable, pump word, divide ratio.
// - IF feedback word holds swallow, main count, output bits and control word.
// - RF feedback word holds numerator, A, B, C counts and the control word.
// - Digital lock rises after 5 good cycles below 15 ns and falls on one above 30 ns; the code counts as good only errors under 3 core clocks (12 ns).
module synth_serial_program_regs
(
  input  wire logic                    core_clk,
  input  wire logic                    rst,
  input  wire logic                    serial_clk,
  input  wire logic                    serial_data,
  input  wire logic                    load_strobe,
  input  wire logic                    if_osc_in,
  input  wire logic                    rf_osc_in,
  input  wire logic                    analog_lock,
  input  wire logic                    if_phase_err,
  input  wire logic                    if_cmp_done,
  input  wire logic                    rf_phase_err,
  input  wire logic                    rf_cmp_done,
  input  wire logic                    if_fb_out,
  input  wire logic                    rf_fb_out,
  output synth_prog_pkg::if_ref_fields_t if_ref_fields,
  output synth_prog_pkg::rf_ref_fields_t rf_ref_fields,
  output synth_prog_pkg::if_fb_fields_t  if_fb_fields,
  output synth_prog_pkg::rf_fb_fields_t  rf_fb_fields,
  output logic [4:0]                   frac_modulus,
  output logic [9:0]                   ifloop_pump_ua,
  output logic                         ifloop_pump_up_on_high,
  output logic                         if_ref_tick,
  output logic                         rf_ref_tick,
  output logic                         if_locked,
  output logic                         rf_locked,
  output logic                         multifunction_pin
);
  import synth_prog_pkg::*;

  // Three-stage samplers for the asynchronous pins
  logic [2:0] sclk_s, sdat_s, load_s, ifo_s, rfo_s;
  logic       sclk_q, load_q, ifo_q, rfo_q;
  logic       next_sclk_q, next_load_q, next_ifo_q, next_rfo_q;

  // A pin level is taken only once stages two and three agree, so a glitch cannot count
  always_comb begin
    next_sclk_q = (sclk_s[1] == sclk_s[2]) ? sclk_s[2] : sclk_q;
    next_load_q = (load_s[1] == load_s[2]) ? load_s[2] : load_q;
    next_ifo_q  = (ifo_s[1] == ifo_s[2]) ? ifo_s[2] : ifo_q;
    next_rfo_q  = (rfo_s[1] == rfo_s[2]) ? rfo_s[2] : rfo_q;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sclk_s <= 3'h0;
      sdat_s <= 3'h0;
      load_s <= 3'h0;
      ifo_s  <= 3'h0;
      rfo_s  <= 3'h0;
      sclk_q <= 1'b0;
      load_q <= 1'b0;
      ifo_q  <= 1'b0;
      rfo_q  <= 1'b0;
    end else begin
      sclk_s <= {sclk_s[1:0], serial_clk};
      sdat_s <= {sdat_s[1:0], serial_data};
      load_s <= {load_s[1:0], load_strobe};
      ifo_s  <= {ifo_s[1:0], if_osc_in};
      rfo_s  <= {rfo_s[1:0], rf_osc_in};
      sclk_q <= next_sclk_q;
      load_q <= next_load_q;
      ifo_q  <= next_ifo_q;
      rfo_q  <= next_rfo_q;
    end
  end

  // Rising edges count once stage two and three agree on the new level
  logic sclk_rise, load_rise, ifo_rise, rfo_rise;
  assign sclk_rise = (sclk_s[2:1] == 2'b11) && !sclk_q;
  assign load_rise = (load_s[2:1] == 2'b11) && !load_q;
  assign ifo_rise  = (ifo_s[2:1] == 2'b11) && !ifo_q;
  assign rfo_rise  = (rfo_s[2:1] == 2'b11) && !rfo_q;

  // Shift register and latch bank; data sampled in the same aligned stage as clock
  logic [WORD_W-1:0] shift_reg, next_shift_reg;
  logic [WORD_W-1:0] latch_word [NUM_LATCHES];
  logic [WORD_W-1:0] next_latch_word [NUM_LATCHES];
  logic [CODE_W-1:0] latch_select_code;
  logic [PAYLOAD_W-1:0] payload;
  assign latch_select_code = shift_reg[CODE_W-1:0];
  assign payload           = shift_reg[WORD_W-1:CODE_W];

  always_comb begin
    next_shift_reg = shift_reg;
    if (sclk_rise) begin
      next_shift_reg = {shift_reg[WORD_W-2:0], sdat_s[2]};
    end
    for (int i = 0; i < NUM_LATCHES; i++) begin
      next_latch_word[i] = latch_word[i];
      if (load_rise && latch_select_code == 2'(i)) begin
        next_latch_word[i] = shift_reg;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      shift_reg <= WORD_RESET;
      for (int i = 0; i < NUM_LATCHES; i++) latch_word[i] <= WORD_RESET;
    end else begin
      shift_reg <= next_shift_reg;
      for (int i = 0; i < NUM_LATCHES; i++) latch_word[i] <= next_latch_word[i];
    end
  end

  // Field decode straight from the stored words
  assign if_ref_fields = if_ref_fields_t'(latch_word[SEL_IF_REF][WORD_W-1:CODE_W]);
  assign rf_ref_fields = rf_ref_fields_t'(latch_word[SEL_RF_REF][WORD_W-1:CODE_W]);
  assign if_fb_fields  = if_fb_fields_t'(latch_word[SEL_IF_FB][WORD_W-1:CODE_W]);
  assign rf_fb_fields  = rf_fb_fields_t'(latch_word[SEL_RF_FB][WORD_W-1:CODE_W]);

  assign frac_modulus = if_ref_fields.frac_modulus_select ? FRAC_MOD_16 : FRAC_MOD_15;
  assign ifloop_pump_ua = if_ref_fields.ifloop_pump_gain ? PUMP_8X_UA : PUMP_1X_UA;
  assign ifloop_pump_up_on_high = if_ref_fields.ifloop_detector_polarity;

  // Reference dividers; sharing lets the IF input clock the RF counter too
  logic rf_ref_edge;
  assign rf_ref_edge = if_ref_fields.ref_input_sharing ? ifo_rise : rfo_rise;
  logic [REF_DIV_W-1:0] if_ref_cnt, rf_ref_cnt, next_if_ref_cnt, next_rf_ref_cnt;
  logic [REF_DIV_W-1:0] if_div, rf_div;
  logic next_if_tick, next_rf_tick;
  // Values below the minimum are clamped; the host must not program them
  assign if_div = (if_ref_fields.ifloop_ref_divide < REF_DIV_MIN) ? REF_DIV_MIN
                  : if_ref_fields.ifloop_ref_divide;
  assign rf_div = (rf_ref_fields.rfloop_ref_divide < REF_DIV_MIN) ? REF_DIV_MIN
                  : rf_ref_fields.rfloop_ref_divide;

  always_comb begin
    next_if_ref_cnt = if_ref_cnt;
    next_rf_ref_cnt = rf_ref_cnt;
    next_if_tick    = 1'b0;
    next_rf_tick    = 1'b0;
    if (ifo_rise) begin
      if (if_ref_cnt >= if_div - 15'h0001) begin
        next_if_ref_cnt = 15'h0000;
        next_if_tick    = 1'b1;
      end else begin
        next_if_ref_cnt = if_ref_cnt + 15'h0001;
      end
    end
    if (rf_ref_edge) begin
      if (rf_ref_cnt >= rf_div - 15'h0001) begin
        next_rf_ref_cnt = 15'h0000;
        next_rf_tick    = 1'b1;
      end else begin
        next_rf_ref_cnt = rf_ref_cnt + 15'h0001;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      if_ref_cnt  <= 15'h0000;
      rf_ref_cnt  <= 15'h0000;
      if_ref_tick <= 1'b0;
      rf_ref_tick <= 1'b0;
    end else begin
      if_ref_cnt  <= next_if_ref_cnt;
      rf_ref_cnt  <= next_rf_ref_cnt;
      if_ref_tick <= next_if_tick;
      rf_ref_tick <= next_rf_tick;
    end
  end

  // Digital lock filters, one per loop
  lock_filter u_if_lock (
    .core_clk   (core_clk),
    .rst        (rst),
    .err_active (if_phase_err),
    .cmp_done   (if_cmp_done),
    .locked     (if_locked)
  );
  lock_filter u_rf_lock (
    .core_clk   (core_clk),
    .rst        (rst),
    .err_active (rf_phase_err),
    .cmp_done   (rf_cmp_done),
    .locked     (rf_locked)
  );

  // Multifunction pin routing, registered
  logic next_mf;
  always_comb begin
    case (if_ref_fields.output_mux_select)
      MUX_ANALOG_LD: next_mf = analog_lock;
      MUX_IF_DLD:    next_mf = if_locked;
      MUX_RF_DLD:    next_mf = rf_locked;
      MUX_BOTH_DLD:  next_mf = if_locked & rf_locked;
      MUX_IF_REF:    next_mf = if_ref_tick;
      MUX_IF_FB:     next_mf = if_fb_out;
      MUX_RF_REF:    next_mf = rf_ref_tick;
      MUX_RF_FB:     next_mf = rf_fb_out;
      default:       next_mf = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) multifunction_pin <= 1'b0;
    else     multifunction_pin <= next_mf;
  end

  // Checks
  a_shift_step: assert property (@(posedge core_clk) disable iff (rst)
    sclk_rise |=> shift_reg == {$past(shift_reg[WORD_W-2:0]), $past(sdat_s[2])})
    else $error("shift step wrong");
  a_latch_load: assert property (@(posedge core_clk) disable iff (rst)
    load_rise |=> latch_word[$past(latch_select_code)] == $past(shift_reg))
    else $error("latch load wrong");
  a_if_ref_hold: assert property (@(posedge core_clk) disable iff (rst)
    !(load_rise && latch_select_code == SEL_IF_REF) |=> $stable(latch_word[SEL_IF_REF]))
    else $error("unselected latch changed");
  a_rf_fb_hold: assert property (@(posedge core_clk) disable iff (rst)
    !(load_rise && latch_select_code == SEL_RF_FB) |=> $stable(latch_word[SEL_RF_FB]))
    else $error("unselected RF feedback changed");
  a_frac_mod: assert property (@(posedge core_clk) disable iff (rst)
    frac_modulus == (latch_word[SEL_IF_REF][22] ? 5'h10 : 5'h0F))
    else $error("modulus wrong");
  a_pump_gain: assert property (@(posedge core_clk) disable iff (rst)
    ifloop_pump_ua == (latch_word[SEL_IF_REF][18] ? 10'h320 : 10'h064))
    else $error("pump current wrong");
  a_field_map: assert property (@(posedge core_clk) disable iff (rst)
    if_ref_fields.ifloop_ref_divide == latch_word[SEL_IF_REF][16:2]
    && rf_fb_fields.frac_numerator == latch_word[SEL_RF_FB][5:2])
    else $error("field map wrong");
  a_mux_analog: assert property (@(posedge core_clk) disable iff (rst)
    if_ref_fields.output_mux_select == MUX_ANALOG_LD && $stable(if_ref_fields)
    |=> multifunction_pin == $past(analog_lock))
    else $error("mux analog wrong");
  a_share_tick: assert property (@(posedge core_clk) disable iff (rst)
    if_ref_fields.ref_input_sharing && !ifo_rise |=> !rf_ref_tick)
    else $error("shared tick wrong");
  // Long error with no judgement inside it, then a short quiet gap before the judgement
  a_unlock_bad: assert property (@(posedge core_clk) disable iff (rst)
    (if_phase_err && !if_cmp_done) [*8] ##1 (!if_cmp_done) [*2] ##1 if_cmp_done
    |=> !if_locked)
    else $error("lock not dropped");
  c_load_if_ref: cover property (@(posedge core_clk) load_rise && latch_select_code == SEL_IF_REF);
  c_load_rf_fb:  cover property (@(posedge core_clk) load_rise && latch_select_code == SEL_RF_FB);
  c_if_lock:     cover property (@(posedge core_clk) $rose(if_locked));
  c_rf_tick:     cover property (@(posedge core_clk) rf_ref_tick);
endmodule // synth_serial_program_regs

/* synth_prog_pkg.sv */
// Package with field layouts and constants for the serial programming block
package synth_prog_pkg;
  localparam int WORD_W      = 24;
  localparam int CODE_W      = 2;
  localparam int PAYLOAD_W   = 22;
  localparam int NUM_LATCHES = 4;
  // Latch select codes
  localparam logic [1:0] SEL_IF_REF = 2'h0;
  localparam logic [1:0] SEL_IF_FB  = 2'h1;
  localparam logic [1:0] SEL_RF_REF = 2'h2;
  localparam logic [1:0] SEL_RF_FB  = 2'h3;
  // Word reset value
  localparam logic [23:0] WORD_RESET = 24'h000000;
  // Counter widths
  localparam int REF_DIV_W = 15;
  localparam int IF_FB_W   = 15;
  localparam int RF_FB_W   = 19;
  localparam logic [14:0] REF_DIV_MIN = 15'h0003;
  // Fractional moduli
  localparam logic [4:0] FRAC_MOD_16 = 5'h10;
  localparam logic [4:0] FRAC_MOD_15 = 5'h0F;
  // Pump current in microamps
  localparam logic [9:0] PUMP_1X_UA = 10'h064;
  localparam logic [9:0] PUMP_8X_UA = 10'h320;
  // Output mux encodings
  localparam logic [2:0] MUX_ANALOG_LD = 3'h0;
  localparam logic [2:0] MUX_IF_DLD    = 3'h4;
  localparam logic [2:0] MUX_RF_DLD    = 3'h2;
  localparam logic [2:0] MUX_BOTH_DLD  = 3'h6;
  localparam logic [2:0] MUX_IF_REF    = 3'h1;
  localparam logic [2:0] MUX_IF_FB     = 3'h5;
  localparam logic [2:0] MUX_RF_REF    = 3'h3;
  localparam logic [2:0] MUX_RF_FB     = 3'h7;
  // Lock detect thresholds
  localparam int LOCK_GOOD_NS     = 15;
  localparam int LOCK_BAD_NS      = 30;
  localparam int LOCK_GOOD_CYCLES = 5;
  localparam int CLK_PERIOD_NS    = 4;
  localparam int LOCK_GOOD_CLKS   = LOCK_GOOD_NS / CLK_PERIOD_NS;
  localparam int LOCK_BAD_CLKS    = (LOCK_BAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef struct packed {
    logic        ref_input_sharing;
    logic        frac_modulus_select;
    logic [2:0]  output_mux_select;
    logic        ifloop_pump_gain;
    logic        ifloop_detector_polarity;
    logic [14:0] ifloop_ref_divide;
  } if_ref_fields_t;

  typedef struct packed {
    logic        dll_fast;
    logic        voltage_doubler_enable;
    logic [4:0]  rfloop_pump_word;
    logic [14:0] rfloop_ref_divide;
  } rf_ref_fields_t;

  typedef struct packed {
    logic [2:0]  ifloop_control_word;
    logic [3:0]  cmos_bits;
    logic [11:0] ifloop_main_count;
    logic [2:0]  ifloop_swallow_count;
  } if_fb_fields_t;

  typedef struct packed {
    logic [2:0]  rfloop_control_word;
    logic [10:0] c_count;
    logic [1:0]  b_count;
    logic [1:0]  a_count;
    logic [3:0]  frac_numerator;
  } rf_fb_fields_t;
endpackage

/* lock_filter.sv */
// Digital lock filter: phase error width against good and bad thresholds
`timescale 1ns/1ns
module lock_filter
(
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic err_active,
  input  wire logic cmp_done,
  output logic      locked
);
  import synth_prog_pkg::*;

  logic [7:0] err_len;
  logic [7:0] next_err_len;
  logic [2:0] good_cnt;
  logic [2:0] next_good_cnt;
  logic       bad_seen;
  logic       next_bad_seen;
  logic       next_locked;

  // Measure error pulse width; judge each cycle at cmp_done
  always_comb begin
    next_err_len  = err_len;
    next_good_cnt = good_cnt;
    next_bad_seen = bad_seen;
    next_locked   = locked;
    if (err_active && err_len != 8'hFF) begin
      next_err_len = err_len + 8'h01;
    end
    if (err_len >= 8'(LOCK_BAD_CLKS)) begin
      next_bad_seen = 1'b1;
    end
    if (cmp_done) begin
      next_err_len  = 8'h00;
      next_bad_seen = 1'b0;
      if (bad_seen || err_len >= 8'(LOCK_BAD_CLKS)) begin
        next_good_cnt = 3'h0;
        next_locked   = 1'b0;
      end else if (err_len < 8'(LOCK_GOOD_CLKS)) begin
        if (good_cnt == 3'(LOCK_GOOD_CYCLES - 1)) begin
          next_locked = 1'b1;
        end else begin
          next_good_cnt = good_cnt + 3'h1;
        end
      end else begin
        next_good_cnt = 3'h0; // Middle band restarts the run without unlocking
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      err_len  <= 8'h00;
      good_cnt <= 3'h0;
      bad_seen <= 1'b0;
      locked   <= 1'b0;
    end else begin
      err_len  <= next_err_len;
      good_cnt <= next_good_cnt;
      bad_seen <= next_bad_seen;
      locked   <= next_locked;
    end
  end
endmodule // lock_filter

/* synth_host_model.sv */
// Host-side model that drives the three-wire serial programming link
`timescale 1ns/1ns
module synth_host_model #(
  parameter int HALF = 15
) (
  input  wire logic core_clk,
  output logic      serial_clk,
  output logic      serial_data,
  output logic      load_strobe
);
  // Link starts low; it stands still between frames
  initial begin
    serial_clk  = 1'b0;
    serial_data = 1'b0;
    load_strobe = 1'b0;
  end

  // Wait a number of core clock edges
  task automatic wait_clk(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // Shift the low n bits of w, then pulse the load strobe
  task automatic send(input logic [31:0] w, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      serial_data <= w[i];
      wait_clk(HALF);
      serial_clk <= 1'b1;
      wait_clk(HALF + 1);
      serial_clk <= 1'b0;
    end
    // Released data line flips so a stale bit can never pass as valid
    serial_data <= ~w[0];
    wait_clk(8);
    load_strobe <= 1'b1;
    wait_clk(8);
    load_strobe <= 1'b0;
    wait_clk(8);
  endtask
endmodule // synth_host_model

/* synth_serial_program_regs_test.sv */
// Self-checking bench for the serial programming front end
`timescale 1ns/1ns
module synth_serial_program_regs_test;
  import synth_prog_pkg::*;
  logic           core_clk, rst, serial_clk, serial_data, load_strobe;
  logic           if_osc_in, rf_osc_in, analog_lock, phase_err, cmp_done;
  logic           if_fb_out, rf_fb_out, if_ref_tick, rf_ref_tick;
  logic           if_locked, rf_locked, multifunction_pin, ifloop_pump_up_on_high;
  if_ref_fields_t if_ref_fields;
  rf_ref_fields_t rf_ref_fields;
  if_fb_fields_t  if_fb_fields;
  rf_fb_fields_t  rf_fb_fields;
  logic [4:0]     frac_modulus;
  logic [9:0]     ifloop_pump_ua;
  logic [3:0]     osc_cnt = 4'h0;
  logic [21:0]    shadow [4];
  logic [21:0]    pl [4];
  logic [2:0]     mux_tab [6] = '{3'h0, 3'h4, 3'h2, 3'h6, 3'h5, 3'h7};
  int             n_errors, compares, n_if, n_rf, n_pin;

  synth_serial_program_regs u_dut (
    .core_clk(core_clk), .rst(rst), .serial_clk(serial_clk),
    .serial_data(serial_data), .load_strobe(load_strobe),
    .if_osc_in(if_osc_in), .rf_osc_in(rf_osc_in), .analog_lock(analog_lock),
    .if_phase_err(phase_err), .if_cmp_done(cmp_done),
    .rf_phase_err(phase_err), .rf_cmp_done(cmp_done),
    .if_fb_out(if_fb_out), .rf_fb_out(rf_fb_out),
    .if_ref_fields(if_ref_fields), .rf_ref_fields(rf_ref_fields),
    .if_fb_fields(if_fb_fields), .rf_fb_fields(rf_fb_fields),
    .frac_modulus(frac_modulus), .ifloop_pump_ua(ifloop_pump_ua),
    .ifloop_pump_up_on_high(ifloop_pump_up_on_high),
    .if_ref_tick(if_ref_tick), .rf_ref_tick(rf_ref_tick),
    .if_locked(if_locked), .rf_locked(rf_locked),
    .multifunction_pin(multifunction_pin)
  );

  synth_host_model u_host (
    .core_clk(core_clk), .serial_clk(serial_clk),
    .serial_data(serial_data), .load_strobe(load_strobe)
  );

  // 250 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // Reference inputs: IF period 8 clocks, RF period 16 clocks
  always @(posedge core_clk) begin
    osc_cnt   <= osc_cnt + 4'h1;
    if_osc_in <= osc_cnt[2];
    rf_osc_in <= osc_cnt[3];
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // All four latches against the shadow copy
  task automatic chk_all();
    chk(if_ref_fields, shadow[0]);
    chk(if_fb_fields, shadow[1]);
    chk(rf_ref_fields, shadow[2]);
    chk(rf_fb_fields, shadow[3]);
  endtask

  // One comparison cycle with an error pulse of e clocks
  task automatic cmp(input int e);
    phase_err <= 1'b1;
    wait_clk(e);
    phase_err <= 1'b0;
    wait_clk(2);
    cmp_done <= 1'b1;
    wait_clk(1);
    cmp_done <= 1'b0;
    wait_clk(3);
  endtask

  // Pin source per mux code; lock codes assume both loops locked
  function automatic logic mux_exp(input logic [2:0] m, input logic v);
    case (m)
      3'h0: return v;
      3'h5: return ~v;
      3'h7: return v;
      default: return 1'b1;
    endcase
  endfunction

  task automatic done_test(input string s);
    $display("test %s done", s);
  endtask

  task automatic stop_test();
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Watchdog: the sequence needs roughly 11000 clocks
  initial begin
    wait_clk(40000);
    n_errors++;
    $display("[ERR] t=%0t seen=%h exp=%h", $time, 32'h0, 32'h1);
    stop_test();
  end

  // Main sequence
  initial begin
    rst = 1'b1;
    {analog_lock, phase_err, cmp_done, if_fb_out, rf_fb_out} = 5'h00;
    n_errors = 0;
    compares = 0;
    for (int i = 0; i < 4; i++) shadow[i] = '0;
    wait_clk(20);
    rst <= 1'b0;
    wait_clk(2);
    chk_all();
    chk(frac_modulus, FRAC_MOD_15);
    chk(ifloop_pump_ua, PUMP_1X_UA);
    chk(ifloop_pump_up_on_high, 1'b0);
    analog_lock <= 1'b1;
    wait_clk(3);
    chk(multifunction_pin, 1'b1);
    done_test("reset");
    // Each code fills only its own latch; earlier ones must hold
    pl[0] = {2'b00, 3'h0, 2'b00, 15'h0003};
    pl[1] = 22'h2AAAA5;
    pl[2] = {1'b1, 1'b0, 5'h15, 15'h0005};
    pl[3] = 22'h15555A;
    for (int c = 0; c < 4; c++) begin
      u_host.send({pl[c], c[1:0]}, 24);
      shadow[c] = pl[c];
      chk_all();
    end
    done_test("latches");
    // Four junk bits ahead of the word must fall off the top
    pl[0] = {1'b0, 1'b1, 3'h0, 2'b11, 15'h0003};
    u_host.send({4'hF, pl[0], 2'b00}, 28);
    shadow[0] = pl[0];
    chk_all();
    chk(frac_modulus, FRAC_MOD_16);
    chk(ifloop_pump_ua, PUMP_8X_UA);
    chk(ifloop_pump_up_on_high, 1'b1);
    done_test("overlength");
    // Divide by 3 and 5, without and with shared reference input
    for (int s = 0; s < 2; s++) begin
      u_host.send({s[0], 1'b0, s[0] ? 3'h3 : 3'h1, 2'b00, 15'h0003, 2'b00}, 24);
      wait_clk(64);
      {n_if, n_rf, n_pin} = '0;
      repeat (240) begin
        @(posedge core_clk);
        n_if += int'(if_ref_tick === 1'b1);
        n_rf += int'(rf_ref_tick === 1'b1);
        n_pin += int'(multifunction_pin === 1'b1);
      end
      chk(n_if, 10);
      chk(n_rf, s ? 6 : 3);
      chk(n_pin, s ? 6 : 10);
    end
    done_test("dividers");
    // Lock needs exactly five good comparisons
    for (int k = 1; k <= 5; k++) begin
      cmp(1);
      chk(if_locked, k == 5);
      chk(rf_locked, k == 5);
    end
    for (int k = 0; k < 6; k++) begin
      u_host.send({2'b00, mux_tab[k], 2'b00, 15'h0003, 2'b00}, 24);
      for (int v = 0; v < 2; v++) begin
        analog_lock <= v[0];
        if_fb_out <= ~v[0];
        rf_fb_out <= v[0];
        wait_clk(4);
        chk(multifunction_pin, mux_exp(mux_tab[k], v[0]));
      end
    end
    // A single long error drops both locks
    cmp(10);
    chk(if_locked, 1'b0);
    chk(rf_locked, 1'b0);
    done_test("lock_and_mux");
    stop_test();
  end
endmodule // synth_serial_program_regs_test
